// *** src/port_bank.sv ***
`timescale 1ns/1ns
module port_bank
	import port_pkg::*;
#(
	parameter int unsigned      WIDTH     = 8,
	parameter logic [WIDTH-1:0] DIR_RESET = {WIDTH{1'b1}}
)
(
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst,
	// register side
	input  wire logic             latch_we,
	input  wire logic [WIDTH-1:0] latch_wdata,
	input  wire logic             dir_we,
	input  wire logic [WIDTH-1:0] dir_wdata,
	input  wire logic [WIDTH-1:0] release_mask,
	// state seen by software
	output logic      [WIDTH-1:0] latch,
	output logic      [WIDTH-1:0] dir,
	output logic      [WIDTH-1:0] read_value,
	// pins
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_out,
	output logic      [WIDTH-1:0] pin_oe
);

	// [RL2] [RL3] latch changes only on write, zero at reset
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			latch <= '0;
		else if (latch_we)
			latch <= latch_wdata;
	end

	// [RL7] direction, 1 selects input
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			dir <= DIR_RESET;
		else if (dir_we)
			dir <= dir_wdata;
	end

	// [RL17] every bit has its own latch, direction, driver, sampler
	// [RL5] [RL6] inputs read the pin, outputs read the latch
	assign read_value = (dir & pin_in) | (~dir & latch);
	// [RL1] [RL4] driver on only for output bits not released
	assign pin_out    = latch;
	assign pin_oe     = ~dir & ~release_mask;

endmodule : port_bank

// *** src/port_latch_read_write.sv ***
// What this block does
// [RL1] output mode: write loads latch, pin drives it
// [RL2] latch holds value until next write
// [RL3] reset clears every output latch bit
// [RL4] input mode: write updates latch, pin undriven
// [RL5] output bit reads return latch value
// [RL6] input bit reads return pin level
// [RL7] direction bit one selects input
// [RL8] output-mode operation uses latch operand, writes back
// [RL9] input-mode operation uses pin level operand
// [RL10] bit set/clear is byte read-modify-write
// [RL11] software rewrites latch before switching to output
// [RL12] analog config and direction pick pin function
// [RL13] oscillator mode resets to zero, pins are ports
// [RL14] software selects oscillator mode before clock use
// [RL15] selected clock pins ignore direction and latch
// [RL16] segment and crystal pins double as debug pins
// [RL17] eight independent bits, each with own controls
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ns
module port_latch_read_write
	import port_pkg::*;
(
	// clock and reset
	input  wire logic                sys_clk,
	input  wire logic                rst,
	// axi4-lite write address and data
	input  wire logic [ADDR_W-1:0]   awaddr,
	input  wire logic                awvalid,
	output logic                     awready,
	input  wire logic [31:0]         wdata,
	input  wire logic [3:0]          wstrb,
	input  wire logic                wvalid,
	output logic                     wready,
	// axi4-lite write response
	output logic [1:0]               bresp,
	output logic                     bvalid,
	input  wire logic                bready,
	// axi4-lite read
	input  wire logic [ADDR_W-1:0]   araddr,
	input  wire logic                arvalid,
	output logic                     arready,
	output logic [31:0]              rdata,
	output logic [1:0]               rresp,
	output logic                     rvalid,
	input  wire logic                rready,
	// analog-capable port pins
	input  wire logic [PORT_A_W-1:0] port_a_pin_in,
	output logic [PORT_A_W-1:0]      port_a_pin_out,
	output logic [PORT_A_W-1:0]      port_a_pin_oe,
	output logic [PORT_A_W-1:0]      analog_convert_sel,
	// oscillator-capable port pins
	input  wire logic [CLK_W-1:0]    clk_pin_in,
	output logic [CLK_W-1:0]         clk_pin_out,
	output logic [CLK_W-1:0]         clk_pin_oe,
	output logic [CLK_W-1:0]         osc_function,
	// on-chip debug
	input  wire logic                debug_enable,
	input  wire logic [1:0]          seg_pin_in,
	output logic [3:0]               debug_mode_pins
);

	wr_state_t           wr_state;
	rd_state_t           rd_state;
	logic                aw_held;
	logic                w_held;
	logic [ADDR_W-1:0]   wr_addr;
	logic [31:0]         wr_data;
	logic                wr_lane0;
	logic [PORT_A_W-1:0] analog_pin_config;
	logic [2:0]          analog_channel_select;
	logic [7:0]          oscillator_mode_select;

	// write channel handshakes, both parts may come in either order
	assign awready = (wr_state == WR_IDLE) && !aw_held;
	assign wready  = (wr_state == WR_IDLE) && !w_held;
	assign bvalid  = (wr_state == WR_RESP);
	assign arready = (rd_state == RD_IDLE);
	assign rvalid  = (rd_state == RD_DATA);

	wire wr_go  = (wr_state == WR_IDLE) && aw_held && w_held;
	wire aw_hs  = awvalid && awready;
	wire w_hs   = wvalid && wready;
	wire ar_hs  = arvalid && arready;

	// address capture
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			aw_held <= 1'b0;
			wr_addr <= '0;
		end
		else if (aw_hs)
		begin
			aw_held <= 1'b1;
			wr_addr <= awaddr;
		end
		else if (wr_go)
			aw_held <= 1'b0;
	end

	// data capture; only lane 0 gates register effects
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			w_held   <= 1'b0;
			wr_data  <= '0;
			wr_lane0 <= 1'b0;
		end
		else if (w_hs)
		begin
			w_held   <= 1'b1;
			wr_data  <= wdata;
			wr_lane0 <= wstrb[0];
		end
		else if (wr_go)
			w_held <= 1'b0;
	end

	// write address decode on the aligned word
	wire [ADDR_W-1:0] wr_word  = {wr_addr[ADDR_W-1:2], 2'b00};
	wire hit_w_data_a  = (wr_word == OFF_PORT_DATA);
	wire hit_w_dir_a   = (wr_word == OFF_PORT_DIR);
	wire hit_w_analog  = (wr_word == OFF_ANALOG_CFG);
	wire hit_w_ads     = (wr_word == OFF_ANALOG_SEL);
	wire hit_w_bit     = (wr_word == OFF_BIT_MANIP);
	wire hit_w_op      = (wr_word == OFF_OPERATE);
	wire hit_w_data_c  = (wr_word == OFF_CLK_DATA);
	wire hit_w_dir_c   = (wr_word == OFF_CLK_DIR);
	wire hit_w_osc     = (wr_word == OFF_OSC_MODE);
	wire hit_w_ro      = (wr_word == OFF_STATUS) || (wr_word == OFF_PIN_LEVEL);
	wire wr_mapped     = hit_w_data_a || hit_w_dir_a || hit_w_analog || hit_w_ads || hit_w_bit || hit_w_op
		|| hit_w_data_c || hit_w_dir_c || hit_w_osc || hit_w_ro;
	wire wr_fire       = wr_go && wr_lane0;

	// write response state
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			wr_state <= WR_IDLE;
			bresp    <= RESP_OKAY;
		end
		else
		begin
			case (wr_state)
				WR_IDLE:
					if (wr_go)
					begin
						wr_state <= WR_RESP;
						bresp    <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
					end
				WR_RESP:
					if (bready)
						wr_state <= WR_IDLE;
				default:
					wr_state <= WR_IDLE;
			endcase
		end
	end

	logic [PORT_A_W-1:0] pa_latch;
	logic [PORT_A_W-1:0] pa_dir;
	logic [PORT_A_W-1:0] pa_read;
	logic [CLK_W-1:0]    pc_latch;
	logic [CLK_W-1:0]    pc_dir;
	logic [CLK_W-1:0]    pc_read;

	wire [2:0] bit_idx  = wr_data[BIT_IDX_LSB +: 3];
	wire       bit_val  = wr_data[BIT_VAL_POS];
	wire       bit_pc   = wr_data[BIT_PORT_POS];
	wire [7:0] operand  = wr_data[7:0];
	wire [2:0] op_code  = wr_data[OP_CODE_LSB +: 3];
	wire       op_pc    = wr_data[OP_PORT_POS];
	wire [7:0] pc_read8 = {{(8 - CLK_W){1'b0}}, pc_read};

	// [RL8] [RL9] operands come from the read value: latch or pin per bit
	// [RL10] single-bit change rewrites the whole byte from the read value
	wire [7:0] pa_bit_res = put_bit(pa_read, bit_idx, bit_val);
	wire [7:0] pc_bit_res = put_bit(pc_read8, bit_idx, bit_val);
	wire [7:0] pa_op_res  = apply_op(pa_read, operand, op_code);
	wire [7:0] pc_op_res  = apply_op(pc_read8, operand, op_code);

	// [RL1] [RL4] latch write paths, regardless of direction
	wire pa_bit_we = wr_fire && hit_w_bit && !bit_pc;
	wire pa_op_we  = wr_fire && hit_w_op && !op_pc;
	wire pc_bit_we = wr_fire && hit_w_bit && bit_pc && (bit_idx < 3'(CLK_W));
	wire pc_op_we  = wr_fire && hit_w_op && op_pc;
	wire pa_latch_we = (wr_fire && hit_w_data_a) || pa_bit_we || pa_op_we;
	wire pc_latch_we = (wr_fire && hit_w_data_c) || pc_bit_we || pc_op_we;
	wire [7:0] pa_latch_wd = pa_bit_we ? pa_bit_res : (pa_op_we ? pa_op_res : wr_data[7:0]);
	wire [7:0] pc_latch_wd = pc_bit_we ? pc_bit_res : (pc_op_we ? pc_op_res : wr_data[7:0]);

	// software-written configuration
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			analog_pin_config      <= ANALOG_RESET;
			analog_channel_select  <= ADS_RESET;
			oscillator_mode_select <= OSC_RESET;
		end
		else if (wr_fire)
		begin
			if (hit_w_analog)
				analog_pin_config <= wr_data[PORT_A_W-1:0];
			if (hit_w_ads)
				analog_channel_select <= wr_data[2:0];
			if (hit_w_osc)
				oscillator_mode_select <= wr_data[7:0];
		end
	end

	// [RL12] analog pins never driven; analog with output direction is prohibited
	wire [PORT_A_W-1:0] ads_onehot   = PORT_A_W'(1) << analog_channel_select;
	wire [PORT_A_W-1:0] analog_prohib = analog_pin_config & ~pa_dir;
	assign analog_convert_sel = analog_pin_config & pa_dir & ads_onehot;

	// [RL13] [RL15] oscillator functions claim pins away from the port
	assign osc_function = oscillator_mode_select[CLK_W-1:0];
	wire [CLK_W-1:0] osc_claim =
		(oscillator_mode_select[OSC_MAIN_XTAL] ? PINS_MAIN_XTAL : '0) |
		(oscillator_mode_select[OSC_MAIN_EXT]  ? PINS_MAIN_EXT  : '0) |
		(oscillator_mode_select[OSC_SUB_XTAL]  ? PINS_SUB_XTAL  : '0) |
		(oscillator_mode_select[OSC_SUB_EXT]   ? PINS_SUB_EXT   : '0);
	// [RL16] debug takes the main crystal pins too
	wire [CLK_W-1:0] clk_release = osc_claim | (debug_enable ? PINS_DEBUG : '0);

	port_bank #(
		.WIDTH     (PORT_A_W),
		.DIR_RESET (DIR_A_RESET)
	) u_port_a (
		.sys_clk      (sys_clk),
		.rst          (rst),
		.latch_we     (pa_latch_we),
		.latch_wdata  (pa_latch_wd),
		.dir_we       (wr_fire && hit_w_dir_a),
		.dir_wdata    (wr_data[PORT_A_W-1:0]),
		.release_mask (analog_pin_config),
		.latch        (pa_latch),
		.dir          (pa_dir),
		.read_value   (pa_read),
		.pin_in       (port_a_pin_in),
		.pin_out      (port_a_pin_out),
		.pin_oe       (port_a_pin_oe)
	);

	port_bank #(
		.WIDTH     (CLK_W),
		.DIR_RESET (DIR_C_RESET)
	) u_port_clk (
		.sys_clk      (sys_clk),
		.rst          (rst),
		.latch_we     (pc_latch_we),
		.latch_wdata  (pc_latch_wd[CLK_W-1:0]),
		.dir_we       (wr_fire && hit_w_dir_c),
		.dir_wdata    (wr_data[CLK_W-1:0]),
		.release_mask (clk_release),
		.latch        (pc_latch),
		.dir          (pc_dir),
		.read_value   (pc_read),
		.pin_in       (clk_pin_in),
		.pin_out      (clk_pin_out),
		.pin_oe       (clk_pin_oe)
	);

	// [RL16] debug mode pin levels, registered for a clean output
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			debug_mode_pins <= 4'h0;
		else
			debug_mode_pins <= debug_enable ? {seg_pin_in, clk_pin_in[1:0]} : 4'h0;
	end

	// read address decode; reads never touch any latch
	wire [ADDR_W-1:0] rd_word = {araddr[ADDR_W-1:2], 2'b00};
	wire [31:0] status_word = {23'h0, debug_enable, analog_prohib};
	wire [31:0] level_word  = {20'h0, clk_pin_in, port_a_pin_in};
	wire [31:0] rd_mux =
		(rd_word == OFF_PORT_DATA)  ? {24'h0, pa_read} :
		(rd_word == OFF_PORT_DIR)   ? {24'h0, pa_dir} :
		(rd_word == OFF_ANALOG_CFG) ? {24'h0, analog_pin_config} :
		(rd_word == OFF_ANALOG_SEL) ? {29'h0, analog_channel_select} :
		(rd_word == OFF_CLK_DATA)   ? {28'h0, pc_read} :
		(rd_word == OFF_CLK_DIR)    ? {28'h0, pc_dir} :
		(rd_word == OFF_OSC_MODE)   ? {24'h0, oscillator_mode_select} :
		(rd_word == OFF_STATUS)     ? status_word :
		(rd_word == OFF_PIN_LEVEL)  ? level_word : 32'h0;
	wire rd_mapped = (rd_word == OFF_PORT_DATA) || (rd_word == OFF_PORT_DIR) || (rd_word == OFF_ANALOG_CFG)
		|| (rd_word == OFF_ANALOG_SEL) || (rd_word == OFF_BIT_MANIP) || (rd_word == OFF_OPERATE)
		|| (rd_word == OFF_CLK_DATA) || (rd_word == OFF_CLK_DIR) || (rd_word == OFF_OSC_MODE)
		|| (rd_word == OFF_STATUS) || (rd_word == OFF_PIN_LEVEL);

	// [RL5] [RL6] read data sampled at the address handshake
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			rd_state <= RD_IDLE;
			rdata    <= 32'h0;
			rresp    <= RESP_OKAY;
		end
		else
		begin
			case (rd_state)
				RD_IDLE:
					if (ar_hs)
					begin
						rd_state <= RD_DATA;
						rdata    <= rd_mux;
						rresp    <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
					end
				RD_DATA:
					if (rready)
						rd_state <= RD_IDLE;
				default:
					rd_state <= RD_IDLE;
			endcase
		end
	end

	// checks; per-bit expectation built apart from the datapath
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	wire [7:0] exp_mix  = (pa_dir & port_a_pin_in) | (~pa_dir & pa_latch);
	wire [7:0] exp_mask = 8'h01 << bit_idx;
	wire [7:0] exp_bit  = bit_val ? (exp_mix | exp_mask) : (exp_mix & ~exp_mask);

	sequence s_data_write;
		wr_fire && hit_w_data_a;
	endsequence

	sequence s_bit_write;
		pa_bit_we;
	endsequence

	sequence s_data_read;
		ar_hs && (rd_word == OFF_PORT_DATA) ##1 rvalid;
	endsequence

	// [RL1] latch takes the written byte
	chk_latch_load_write: assert property (s_data_write |=> pa_latch == $past(wr_data[7:0])) // [RL1]
		else $error("data write did not load latch");

	// [RL1] [RL4] driven pins follow the latch, input pins undriven
	chk_pin_drive_mode: assert property ((port_a_pin_oe & pa_dir) == 8'h00 && // [RL4]
		(port_a_pin_out == pa_latch) && ((~pa_dir & ~analog_pin_config) == port_a_pin_oe))
		else $error("pin driver does not match direction");

	// [RL2] latch holds without a write
	chk_latch_hold_value: assert property (!pa_latch_we |=> $stable(pa_latch)) // [RL2]
		else $error("latch changed without write");

	// [RL3] reset clears latches
	chk_reset_clear_latch: assert property (disable iff (1'b0) rst |=> (pa_latch == 8'h00) // [RL3]
		&& (pc_latch == 4'h0))
		else $error("latch not cleared by reset");

	// [RL5] [RL6] [RL7] data read mixes latch and pin per direction
	chk_read_mix_value: assert property (ar_hs && (rd_word == OFF_PORT_DATA) |=> // [RL6]
		rvalid && rdata[7:0] == $past(exp_mix) && ($stable(pa_latch) || $past(pa_latch_we)))
		else $error("port read returned wrong mix");

	// [RL10] [RL9] bit change writes read value with target bit replaced
	chk_bit_rmw_byte: assert property (s_bit_write |=> pa_latch == $past(exp_bit)) // [RL10]
		else $error("bit manipulation result wrong");

	// [RL8] operation on an all-output port uses the latch
	chk_op_latch_src: assert property (pa_op_we && pa_dir == 8'h00 && op_code == OP_XOR |=> // [RL8]
		pa_latch == ($past(pa_latch) ^ $past(operand)))
		else $error("operation did not use latch operand");

	// [RL12] analog pins never driven, prohibited setting flagged
	chk_analog_pin_fn: assert property ((analog_pin_config & port_a_pin_oe) == 8'h00 && // [RL12]
		(analog_convert_sel & ~pa_dir) == 8'h00 && status_word[7:0] == (analog_pin_config & ~pa_dir))
		else $error("analog pin function wrong");

	// [RL13] oscillator mode cleared by reset, pins are ports
	chk_osc_reset_zero: assert property (disable iff (1'b0) rst |=> oscillator_mode_select == 8'h00 // [RL13]
		&& osc_function == 4'h0)
		else $error("oscillator mode not reset");

	// [RL15] claimed clock pins ignore direction and latch
	chk_clock_pin_free: assert property ((osc_claim & clk_pin_oe) == 4'h0) // [RL15]
		else $error("claimed clock pin driven");

	// [RL16] debug pins mirror segment and crystal pins a cycle later
	chk_debug_pin_map: assert property (debug_enable |=> debug_mode_pins == // [RL16]
		{$past(seg_pin_in), $past(clk_pin_in[1:0])} && (clk_pin_oe[1:0] == 2'b00 || !debug_enable))
		else $error("debug pin mapping wrong");

	// write answer the cycle after both parts are held
	chk_write_answer: assert property (wr_go |=> bvalid [*1] ##0 (bresp == $past(wr_mapped ? RESP_OKAY
		: RESP_SLVERR)))
		else $error("write response missing");

	// read answer held until taken
	chk_read_hold: assert property (s_data_read ##0 !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");

endmodule : port_latch_read_write

// *** src/port_pkg.sv ***
package port_pkg;

	// port widths
	localparam int unsigned PORT_A_W = 8;
	localparam int unsigned CLK_W    = 4;
	localparam int unsigned ADDR_W   = 8;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_PORT_DATA  = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_PORT_DIR   = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_ANALOG_CFG = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_ANALOG_SEL = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_BIT_MANIP  = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_OPERATE    = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_CLK_DATA   = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_CLK_DIR    = 8'h1C;
	localparam logic [ADDR_W-1:0] OFF_OSC_MODE   = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_STATUS     = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_PIN_LEVEL  = 8'h28;

	// reset values
	localparam logic [PORT_A_W-1:0] DIR_A_RESET   = 8'hFF;
	localparam logic [CLK_W-1:0]    DIR_C_RESET   = 4'hF;
	localparam logic [PORT_A_W-1:0] ANALOG_RESET  = 8'h00;
	localparam logic [2:0]          ADS_RESET     = 3'h0;
	localparam logic [7:0]          OSC_RESET     = 8'h00;

	// bit manipulation word: [2:0] bit, [3] value, [8] port select
	localparam int unsigned BIT_IDX_LSB  = 0;
	localparam int unsigned BIT_VAL_POS  = 3;
	localparam int unsigned BIT_PORT_POS = 8;
	// operate word: [7:0] operand, [10:8] code, [12] port select
	localparam int unsigned OP_CODE_LSB  = 8;
	localparam int unsigned OP_PORT_POS  = 12;
	// oscillator mode fields
	localparam int unsigned OSC_MAIN_XTAL = 0;
	localparam int unsigned OSC_MAIN_EXT  = 1;
	localparam int unsigned OSC_SUB_XTAL  = 2;
	localparam int unsigned OSC_SUB_EXT   = 3;
	// clock pins taken by each oscillator function and by debug
	localparam logic [CLK_W-1:0] PINS_MAIN_XTAL = 4'h3;
	localparam logic [CLK_W-1:0] PINS_MAIN_EXT  = 4'h2;
	localparam logic [CLK_W-1:0] PINS_SUB_XTAL  = 4'hC;
	localparam logic [CLK_W-1:0] PINS_SUB_EXT   = 4'h8;
	localparam logic [CLK_W-1:0] PINS_DEBUG     = 4'h3;

	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		OP_AND = 3'h0,
		OP_OR  = 3'h1,
		OP_XOR = 3'h2,
		OP_ADD = 3'h3,
		OP_SUB = 3'h4
	} op_t;

	typedef enum logic [1:0] {
		WR_IDLE = 2'h1,
		WR_RESP = 2'h2
	} wr_state_t;

	typedef enum logic [1:0] {
		RD_IDLE = 2'h1,
		RD_DATA = 2'h2
	} rd_state_t;

	// arithmetic or logic step on an 8-bit operand
	function automatic logic [7:0] apply_op(input logic [7:0] a, input logic [7:0] b, input logic [2:0] code);
		logic [7:0] r;
		r = a;
		case (code)
			OP_AND: r = a & b;
			OP_OR:  r = a | b;
			OP_XOR: r = a ^ b;
			OP_ADD: r = 8'(a + b);
			OP_SUB: r = 8'(a - b);
			default: r = a;
		endcase
		return r;
	endfunction : apply_op

	// replace one bit of a byte
	function automatic logic [7:0] put_bit(input logic [7:0] a, input logic [2:0] idx, input logic val);
		logic [7:0] r;
		r = a;
		r[idx] = val;
		return r;
	endfunction : put_bit

endpackage : port_pkg

// *** verif/pin_model.sv ***
`timescale 1ns/1ns
module pin_model
#(
	parameter int unsigned W = 8
)
(
	// design pin side
	input  wire logic [W-1:0] pin_out,
	input  wire logic [W-1:0] pin_oe,
	// level the board puts on an undriven pin
	input  wire logic [W-1:0] board_level,
	output logic      [W-1:0] pin_in
);
	// a driven pin shows its driver, an undriven one the board level
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & board_level);
endmodule : pin_model

// *** verif/port_latch_read_write_test.sv ***
`timescale 1ns/1ns
module port_latch_read_write_test;
	import port_pkg::*;
	logic                sys_clk, rst, awvalid, wvalid, bready, arvalid, rready, debug_enable;
	logic                awready, wready, bvalid, arready, rvalid;
	logic [ADDR_W-1:0]   awaddr, araddr;
	logic [31:0]         wdata, rdata, rd_val;
	logic [3:0]          wstrb, dbg_pins;
	logic [1:0]          bresp, rresp, wr_resp, rd_resp, seg_pin_in;
	logic [PORT_A_W-1:0] a_in, a_out, a_oe, a_board, conv_sel;
	logic [CLK_W-1:0]    c_in, c_out, c_oe, c_board, osc_fn;
	int                  mismatches, total_checks;
	// expected latch after 0F op 33 for codes 0 to 5
	localparam logic [7:0] OP_EXP [6] = '{8'h03, 8'h3F, 8'h3C, 8'h42, 8'hDC, 8'h0F};

	port_latch_read_write port_latch_read_write_i (.sys_clk(sys_clk), .rst(rst),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .port_a_pin_in(a_in), .port_a_pin_out(a_out),
		.port_a_pin_oe(a_oe), .analog_convert_sel(conv_sel), .clk_pin_in(c_in), .clk_pin_out(c_out),
		.clk_pin_oe(c_oe), .osc_function(osc_fn), .debug_enable(debug_enable),
		.seg_pin_in(seg_pin_in), .debug_mode_pins(dbg_pins));
	pin_model #(.W(PORT_A_W)) pin_model_i (.pin_out(a_out), .pin_oe(a_oe), .board_level(a_board), .pin_in(a_in));
	pin_model #(.W(CLK_W)) clk_pin_model_i (.pin_out(c_out), .pin_oe(c_oe), .board_level(c_board), .pin_in(c_in));

	// value compare, counted
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	// bus write, both parts offered together, held until taken
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		logic aw_hs, w_hs, b_hs;
		@(posedge sys_clk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		b_hs = 1'b0;
		while (!b_hs)
		begin
			@(negedge sys_clk);
			aw_hs = awvalid && awready;
			w_hs = wvalid && wready;
			b_hs = bvalid;
			wr_resp = bresp;
			@(posedge sys_clk);
			if (aw_hs) awvalid <= 1'b0;
			if (w_hs) wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask : wr

	// bus read; ready seen mid-cycle so the edge result is known
	task automatic rd(input logic [ADDR_W-1:0] a);
		logic ar_hs, r_hs;
		@(posedge sys_clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		r_hs = 1'b0;
		while (!r_hs)
		begin
			@(negedge sys_clk);
			ar_hs = arvalid && arready;
			r_hs = rvalid;
			rd_val = rdata;
			rd_resp = rresp;
			@(posedge sys_clk);
			if (ar_hs) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask : rd

	task automatic test_reset;
		@(negedge sys_clk);
		check(a_out, 0, "latch after reset"); // latch cleared
		check({c_oe, a_oe}, 0, "drivers after reset"); // all pins ports, inputs
		check(osc_fn, 0, "osc function"); // no clock use
		rd(OFF_OSC_MODE);
		check(rd_val, 0, "osc mode reset"); // mode zero
		rd(OFF_PORT_DIR);
		check(rd_val, 32'hFF, "dir reset");
		wr(8'h40, 32'h1);
		check(wr_resp, RESP_SLVERR, "unmapped write");
		rd(8'h40);
		check(rd_resp, RESP_SLVERR, "unmapped read answer");
		check(rd_val, 0, "unmapped read data");
		$display("test reset done");
	endtask : test_reset

	task automatic test_rw;
		wr(OFF_PORT_DIR, 0);
		wr(OFF_PORT_DATA, 32'hA5);
		@(negedge sys_clk);
		check({a_oe, a_out}, 16'hFFA5, "output pin"); // latch drives pin
		rd(OFF_PORT_DATA);
		check(rd_val, 32'hA5, "output read"); // latch read back
		a_board <= 8'h3C;
		wr(OFF_PORT_DIR, 32'hFF);
		wr(OFF_PORT_DATA, 32'h5A);
		@(negedge sys_clk);
		check({a_oe, a_in}, 16'h003C, "input pin"); // driver stays off
		rd(OFF_PORT_DATA);
		check(rd_val, 32'h3C, "input read"); // pin level read
		wr(OFF_PORT_DIR, 32'h0F);
		rd(OFF_PORT_DATA);
		check(rd_val, 32'h5C, "mixed read"); // one selects input per bit
		wr(OFF_PORT_DIR, 0);
		@(negedge sys_clk);
		check(a_out, 32'h5A, "latch kept"); // latch retained
		$display("test read write done");
	endtask : test_rw

	task automatic test_operate;
		for (int i = 0; i < 6; i++)
		begin
			wr(OFF_PORT_DATA, 32'h0F);
			wr(OFF_OPERATE, (32'(i) << OP_CODE_LSB) | 32'h33);
			rd(OFF_PORT_DATA);
			check(rd_val, 32'(OP_EXP[i]), "operate output"); // latch operand
		end
		a_board <= 8'hF0;
		wr(OFF_PORT_DIR, 32'hFF);
		wr(OFF_PORT_DATA, 0);
		wr(OFF_OPERATE, 32'h10F);
		@(negedge sys_clk);
		check(a_oe, 0, "operate input drive"); // pin stays undriven
		wr(OFF_PORT_DIR, 0);
		@(negedge sys_clk);
		check(a_out, 32'hFF, "operate input"); // pin level operand
		$display("test operate done");
	endtask : test_operate

	task automatic test_bit;
		@(posedge sys_clk);
		a_board <= 8'hFF;
		wr(OFF_PORT_DIR, 32'hFE);
		wr(OFF_PORT_DATA, 0);
		wr(OFF_BIT_MANIP, 32'h8);
		wr(OFF_PORT_DIR, 0);
		@(negedge sys_clk);
		check(a_out, 32'hFF, "bit set copies pins"); // whole byte rewritten
		// rewrite before relying on outputs
		wr(OFF_PORT_DATA, 32'h01); // latch rewritten
		wr(OFF_BIT_MANIP, 0);
		rd(OFF_PORT_DATA);
		check(rd_val, 0, "bit clear"); // target bit cleared
		$display("test bit done");
	endtask : test_bit

	task automatic test_analog;
		wr(OFF_PORT_DIR, 32'hFF);
		wr(OFF_ANALOG_CFG, 32'h01);
		wr(OFF_ANALOG_SEL, 0);
		@(negedge sys_clk);
		check(conv_sel, 32'h01, "convert picked"); // analog input converted
		wr(OFF_ANALOG_SEL, 32'h1);
		@(negedge sys_clk);
		check(conv_sel, 0, "convert not picked"); // not selected
		wr(OFF_PORT_DIR, 32'hFE);
		@(negedge sys_clk);
		check(a_oe, 0, "analog output"); // prohibited, driver off
		rd(OFF_STATUS);
		check(rd_val, 32'h1, "prohibited flag"); // flagged
		wr(OFF_ANALOG_CFG, 0);
		$display("test analog done");
	endtask : test_analog

	task automatic test_osc;
		c_board <= 4'h1;
		wr(OFF_CLK_DIR, 0);
		wr(OFF_CLK_DATA, 32'hF);
		@(negedge sys_clk);
		check({c_oe, c_out}, 8'hFF, "clock pins as port"); // ordinary port
		wr(OFF_OSC_MODE, 32'h1); // mode chosen first
		@(negedge sys_clk);
		check({osc_fn, c_oe}, 8'h1C, "main crystal"); // dir and latch ignored
		wr(OFF_OSC_MODE, 32'h4);
		@(negedge sys_clk);
		check(c_oe, 32'h3, "sub crystal"); // sub pins claimed
		wr(OFF_OSC_MODE, 0);
		wr(OFF_CLK_DIR, 32'hF);
		seg_pin_in <= 2'b10;
		debug_enable <= 1'b1;
		wr(OFF_CLK_DIR, 0);
		@(negedge sys_clk);
		check({dbg_pins, c_oe}, 8'h9C, "debug pins"); // mode pins mirrored
		@(posedge sys_clk);
		debug_enable <= 1'b0;
		$display("test osc done");
	endtask : test_osc

	task automatic test_bus;
		logic hs;
		wr(OFF_CLK_DATA, 32'hF);
		wr(OFF_BIT_MANIP, 32'h102);
		rd(OFF_CLK_DATA);
		check(rd_val, 32'hB, "clock port bit clear"); // byte rewritten
		wr(OFF_OPERATE, 32'h1205);
		rd(OFF_CLK_DATA);
		check(rd_val, 32'hE, "clock port operate"); // latch operand
		wr(OFF_PORT_DIR, 0);
		wr(OFF_PORT_DATA, 32'h96);
		wstrb <= 4'hE;
		wr(OFF_PORT_DATA, 32'h69);
		wstrb <= 4'hF;
		check(wr_resp, RESP_OKAY, "lane 0 off answer");
		@(negedge sys_clk);
		check(a_out, 32'h96, "lane 0 off"); // latch untouched
		// read answer left waiting two cycles before rready
		@(posedge sys_clk);
		araddr  <= OFF_PORT_DATA;
		arvalid <= 1'b1;
		hs = 1'b0;
		while (!hs)
		begin
			@(negedge sys_clk);
			hs = arready;
			@(posedge sys_clk);
		end
		arvalid <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rready <= 1'b1;
		@(negedge sys_clk);
		check(rvalid, 1, "read still offered");
		check(rdata, 32'h96, "read data held"); // latch read back
		@(posedge sys_clk);
		rready <= 1'b0;
		$display("test bus done");
	endtask : test_bus

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim

	// free-running clock
	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// hang guard, well beyond the few hundred cycles used
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		end_sim();
	end

	// main sequence
	initial
	begin
		{rst, awvalid, wvalid, bready, arvalid, rready, debug_enable} = 7'h40;
		{awaddr, araddr, wdata, seg_pin_in, a_board, c_board} = '0;
		wstrb = 4'hF;
		mismatches = 0;
		total_checks = 0;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		test_reset();
		test_rw();
		test_operate();
		test_bit();
		test_analog();
		test_osc();
		test_bus();
		end_sim();
	end
endmodule : port_latch_read_write_test
